// file: rtl/lmbf_defines.vh
/*
  Constants for the LED matrix blink and font RAM block: register addresses,
  configuration field positions, reset values, font pointer limits and blink timing.
  Assumes inclusion by bare name from rtl/ design files only.
*/
`ifndef LMBF_DEFINES_VH
`define LMBF_DEFINES_VH

// ************************************************************
// Register addresses
// ************************************************************
`define LMBF_ADDR_CONFIG 8'h04
`define LMBF_ADDR_FONT 8'h05
`define LMBF_ADDR_PRI_BASE 8'h20
`define LMBF_ADDR_ALT_BASE 8'h40
`define LMBF_ADDR_BOTH_BASE 8'h60

// ************************************************************
// Configuration register fields
// ************************************************************
`define LMBF_CFG_SHDN 0
`define LMBF_CFG_FAST 2
`define LMBF_CFG_BLINK_EN 3
`define LMBF_CFG_SYNC 4
`define LMBF_CFG_CLEAR 5
`define LMBF_CFG_PHASE 7
`define LMBF_CFG_RESET 8'h00

// ************************************************************
// Digit and font values
// ************************************************************
`define LMBF_DIGIT_RESET 8'h20
`define LMBF_DIGIT_CLEAR 8'h00
`define LMBF_FONT_PTR_FIRST 8'h80
`define LMBF_FONT_PTR_LAST 8'hF7
`define LMBF_USER_CODE_LAST 7'h17
`define LMBF_ROM_CODE_FIRST 7'h20

// ************************************************************
// Blink timing: half periods in ms at the multiplex clock rate
// ************************************************************
`define LMBF_SLOW_HALF_MS 1000
`define LMBF_FAST_HALF_MS 500
`define LMBF_CLK_KHZ 20000

`endif

// file: rtl/lmbf_font_ram.v
/*
  User font RAM: 120 entries of seven bits, one write port and one
  asynchronous read port for the register path, plus a glyph read port.
  Assumes addresses below the depth; the caller keeps the pointer in range.
*/
`timescale 1ns/1ps
module lmbf_font_ram #(
  parameter DEPTH = 120,
  parameter AW = 7
) (
  // Clock
  input wire clk,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [6:0] wr_data,
  // Register read port
  input wire [AW-1:0] rd_addr,
  output wire [6:0] rd_data,
  // Glyph read port
  input wire [AW-1:0] gl_addr,
  output wire [6:0] gl_data
);

  reg [6:0] mem_ff [0:DEPTH-1];

  // Storage has no reset; contents are undefined until written, like SRAM
  always @(posedge clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  // Combinational reads so the answer stands in the cycle of the access
  assign rd_data = mem_ff[rd_addr];
  assign gl_data = mem_ff[gl_addr];

endmodule // lmbf_font_ram

// file: rtl/lmbf_blink_timer.v
/*
  Blink phase timer: counts clock cycles for each half period and toggles the
  phase. A sync pulse restarts both the half-period count and the scan sequence.
  Assumes clk is the multiplex clock; shortened counts come in by parameter.
*/
`timescale 1ns/1ps
module lmbf_blink_timer #(
  parameter SLOW_CYC = 20000000,
  parameter FAST_CYC = 10000000,
  parameter SCAN_CYC = 16,
  parameter CW = 25
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire fast,
  input wire sync,
  // Status
  output reg phase_ff,
  output reg [1:0] scan_ff
);

  reg [CW-1:0] cnt_ff;
  reg [7:0] scan_cnt_ff;
  wire [CW-1:0] limit;

  assign limit = fast ? FAST_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1} :
                        SLOW_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

  // Phase toggles forever, blink enabled or not, so readback always moves
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= {CW{1'b0}};
      phase_ff <= 1'b1;
    end else if (sync) begin
      cnt_ff <= {CW{1'b0}};
      phase_ff <= 1'b1;
    end else if (cnt_ff >= limit) begin
      cnt_ff <= {CW{1'b0}};
      phase_ff <= ~phase_ff;
    end else begin
      cnt_ff <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Scan sequence restarts with blink sync; a one-time flicker is accepted
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_cnt_ff <= 8'h00;
      scan_ff <= 2'h0;
    end else if (sync) begin
      scan_cnt_ff <= 8'h00;
      scan_ff <= 2'h0;
    end else if (scan_cnt_ff >= SCAN_CYC[7:0] - 8'h01) begin
      scan_cnt_ff <= 8'h00;
      scan_ff <= scan_ff + 2'h1;
    end else begin
      scan_cnt_ff <= scan_cnt_ff + 8'h01;
    end
  end

endmodule // lmbf_blink_timer

// file: rtl/lmbf_core.v
/*
  LED matrix blink and font RAM control: configuration register blink bits,
  digit plane storage, character code decode, indirect auto-incrementing
  font RAM port and per-column segment output for the scanned digit.
  Assumes a serial bus front end that delivers one byte access per strobe:
  reg_wr / reg_rd are one-cycle pulses issued at the acknowledge of the byte.
*/
`timescale 1ns/1ps
`include "lmbf_defines.vh"

// Summary of operation
// - Blink on: planes pick segment per phase
// - Blink off: primary plane only drives segments
// - Sync bit resets blink counters at acknowledge
// - Sync bit also restarts multiplex scan
// - Clear bit zeroes both digit planes
// - Config read bit 7 returns blink phase
// - Low seven bits pick one of 128
// - Top bit inverts lit and dark dots
// - Codes 0x00-0x17 are user glyphs
// - Codes 0x20-0x7F are ROM characters
// - Font RAM 120 seven-bit entries
// - Font access only through register 0x05
// - MSB write loads pointer, else stores data
// - Font read returns entry, then increments
// - Pointer itself is never readable
// - Access at 0xF7 wraps pointer to 0x80
// - Spare font entries act as storage
// - Pointer load above 0xF7 gives 0x80
// - Slow 1s, fast 0.5s per phase
module lmbf_core #(
  parameter NDIG = 4,
  parameter FONT_DEPTH = 120,
  parameter SLOW_CYC = `LMBF_SLOW_HALF_MS * `LMBF_CLK_KHZ,
  parameter FAST_CYC = `LMBF_FAST_HALF_MS * `LMBF_CLK_KHZ,
  parameter SCAN_CYC = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register access, one byte per strobe
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_ff,
  // Display side
  input wire [2:0] col_sel,
  input wire [6:0] rom_col,
  output reg [6:0] rom_code_ff,
  output reg [1:0] scan_digit_ff,
  output reg [6:0] seg_ff,
  output reg blink_ff,
  output reg shutdown_n_ff
);

  // ************************************************************
  // Declarations
  // ************************************************************
  reg [7:0] cfg_ff;
  reg [7:0] font_ptr_ff;
  reg [7:0] pri_ff [0:NDIG-1];
  reg [7:0] alt_ff [0:NDIG-1];
  reg [7:0] nxt_rdata;
  reg [7:0] nxt_font_ptr;
  reg font_wr;
  reg [6:0] glyph_addr;
  reg [6:0] pri_col;
  reg [6:0] alt_col;
  reg [6:0] nxt_seg;
  wire phase;
  wire [1:0] scan;
  wire [6:0] ram_rdata;
  wire [6:0] ram_gdata;
  wire cfg_wr;
  wire font_acc;
  wire sync_pulse;
  wire clear_pulse;
  integer i;

  // Strip the pointer flag to get the RAM index
  function [6:0] ptr_index;
    input [7:0] p;
    begin
      ptr_index = p[6:0];
    end
  endfunction

  // Advance the pointer, wrapping after the last entry
  function [7:0] ptr_next;
    input [7:0] p;
    begin
      if (p >= `LMBF_FONT_PTR_LAST) begin
        ptr_next = `LMBF_FONT_PTR_FIRST;
      end else begin
        ptr_next = p + 8'h01;
      end
    end
  endfunction

  // Glyph RAM index of a user code and column; eight bits inside so the
  // product cannot wrap before the cut back to the RAM address width
  function [6:0] glyph_index;
    input [4:0] code;
    input [2:0] col;
    reg [7:0] full;
    begin
      full = ({3'h0, code} * 8'h05) + {5'h00, col};
      glyph_index = full[6:0];
    end
  endfunction

  // Column pattern of a character code: user glyph RAM or the ROM lookup
  function [6:0] code_col;
    input [7:0] code;
    input [6:0] ram_col;
    input [6:0] rom_c;
    reg [6:0] raw;
    begin
      raw = 7'h00;
      if (code[6:0] <= `LMBF_USER_CODE_LAST) begin
        raw = ram_col;
      end else begin
        raw = rom_c;
      end
      code_col = code[7] ? ~raw : raw;
    end
  endfunction

  // ************************************************************
  // Submodules
  // ************************************************************
  lmbf_blink_timer #(
    .SLOW_CYC(SLOW_CYC),
    .FAST_CYC(FAST_CYC),
    .SCAN_CYC(SCAN_CYC),
    .CW(25)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .fast(cfg_ff[`LMBF_CFG_FAST]),
    .sync(sync_pulse),
    .phase_ff(phase),
    .scan_ff(scan)
  );

  lmbf_font_ram #(
    .DEPTH(FONT_DEPTH),
    .AW(7)
  ) u_ram (
    .clk(clk),
    .wr_en(font_wr),
    .wr_addr(ptr_index(font_ptr_ff)),
    .wr_data(reg_wdata[6:0]),
    .rd_addr(ptr_index(font_ptr_ff)),
    .rd_data(ram_rdata),
    .gl_addr(glyph_addr),
    .gl_data(ram_gdata)
  );

  // ************************************************************
  // Register decode
  // ************************************************************
  assign cfg_wr = reg_wr && (reg_addr[6:0] == `LMBF_ADDR_CONFIG);
  assign font_acc = reg_addr[6:0] == `LMBF_ADDR_FONT;
  // Sync and clear act only on the write that carries them, never stored
  assign sync_pulse = cfg_wr && reg_wdata[`LMBF_CFG_SYNC];
  assign clear_pulse = cfg_wr && reg_wdata[`LMBF_CFG_CLEAR];

  // Configuration register; action bits are not kept
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= `LMBF_CFG_RESET;
    end else if (cfg_wr) begin
      cfg_ff <= reg_wdata & 8'h0D;
    end
  end

  // Font pointer: load on MSB writes, advance on data accesses only
  always @* begin
    nxt_font_ptr = font_ptr_ff;
    font_wr = 1'b0;
    if (font_acc && reg_wr) begin
      if (reg_wdata[7]) begin
        if (reg_wdata > `LMBF_FONT_PTR_LAST) begin
          nxt_font_ptr = `LMBF_FONT_PTR_FIRST;
        end else begin
          nxt_font_ptr = reg_wdata;
        end
      end else begin
        font_wr = 1'b1;
        nxt_font_ptr = ptr_next(font_ptr_ff);
      end
    end else if (font_acc && reg_rd) begin
      nxt_font_ptr = ptr_next(font_ptr_ff);
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      font_ptr_ff <= `LMBF_FONT_PTR_FIRST;
    end else begin
      font_ptr_ff <= nxt_font_ptr;
    end
  end

  // Digit planes; the shared-write addresses load both at once
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < NDIG; i = i + 1) begin
        pri_ff[i] <= `LMBF_DIGIT_RESET;
        alt_ff[i] <= `LMBF_DIGIT_RESET;
      end
    end else if (clear_pulse) begin
      for (i = 0; i < NDIG; i = i + 1) begin
        pri_ff[i] <= `LMBF_DIGIT_CLEAR;
        alt_ff[i] <= `LMBF_DIGIT_CLEAR;
      end
    end else if (reg_wr) begin
      for (i = 0; i < NDIG; i = i + 1) begin
        if (reg_addr[6:0] == (`LMBF_ADDR_PRI_BASE + i[7:0]) ||
            reg_addr[6:0] == (`LMBF_ADDR_BOTH_BASE + i[7:0])) begin
          pri_ff[i] <= reg_wdata;
        end
        if (reg_addr[6:0] == (`LMBF_ADDR_ALT_BASE + i[7:0]) ||
            reg_addr[6:0] == (`LMBF_ADDR_BOTH_BASE + i[7:0])) begin
          alt_ff[i] <= reg_wdata;
        end
      end
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // Font reads never expose the pointer; shared-write addresses read zero
  always @* begin
    nxt_rdata = 8'h00;
    if (reg_addr[6:0] == `LMBF_ADDR_CONFIG) begin
      nxt_rdata = cfg_ff;
      // Reads the pin itself, so readback and pin never disagree by a cycle
      nxt_rdata[`LMBF_CFG_PHASE] = blink_ff;
    end else if (font_acc) begin
      nxt_rdata = {1'b0, ram_rdata};
    end else begin
      for (i = 0; i < NDIG; i = i + 1) begin
        if (reg_addr[6:0] == (`LMBF_ADDR_PRI_BASE + i[7:0])) begin
          nxt_rdata = pri_ff[i];
        end
        if (reg_addr[6:0] == (`LMBF_ADDR_ALT_BASE + i[7:0])) begin
          nxt_rdata = alt_ff[i];
        end
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ************************************************************
  // Segment generation for the scanned digit
  // ************************************************************
  // Glyph RAM is shared between planes, so primary and alternate columns
  // are looked up in alternate cycles; the output holds the last result.
  reg look_alt_ff;
  reg [6:0] pri_hold_ff;

  always @* begin
    if (look_alt_ff) begin
      glyph_addr = glyph_index(alt_ff[scan][4:0], col_sel);
    end else begin
      glyph_addr = glyph_index(pri_ff[scan][4:0], col_sel);
    end
    pri_col = pri_hold_ff;
    alt_col = code_col(alt_ff[scan], ram_gdata, rom_col);
    if (!cfg_ff[`LMBF_CFG_BLINK_EN]) begin
      nxt_seg = pri_col;
    end else begin
      nxt_seg = phase ? pri_col : alt_col;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      look_alt_ff <= 1'b0;
      pri_hold_ff <= 7'h00;
      seg_ff <= 7'h00;
      rom_code_ff <= `LMBF_ROM_CODE_FIRST;
      scan_digit_ff <= 2'h0;
      blink_ff <= 1'b1;
      shutdown_n_ff <= 1'b0;
    end else begin
      look_alt_ff <= ~look_alt_ff;
      if (!look_alt_ff) begin
        pri_hold_ff <= code_col(pri_ff[scan], ram_gdata, rom_col);
        rom_code_ff <= alt_ff[scan][6:0];
      end else begin
        seg_ff <= nxt_seg;
        rom_code_ff <= pri_ff[scan][6:0];
      end
      scan_digit_ff <= scan;
      blink_ff <= phase;
      shutdown_n_ff <= cfg_ff[`LMBF_CFG_SHDN];
    end
  end

endmodule // lmbf_core

// file: dv/lmbf_core_checker.sv
/* Port assertions for lmbf_core.
   Assumes one clock, async active-high reset, sim blink counts by parameter. */
`timescale 1ns/1ps
module lmbf_checker #(
  parameter SLOW_CYC = 40
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register bus
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_ff,
  // Display side
  input wire [1:0] scan_digit_ff,
  input wire blink_ff
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // ****
  // Helpers
  // ****
  wire cfg_wr = reg_wr && reg_addr[6:0] == 7'h04;
  wire cfg_rd = reg_rd && reg_addr[6:0] == 7'h04;
  reg blink_q_ff;
  integer cnt_ff;
  // Phase length; a sync write restarts it just as it restarts the timer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_q_ff <= 1'b1;
      cnt_ff <= 0;
    end else begin
      blink_q_ff <= blink_ff;
      cnt_ff <= (blink_ff != blink_q_ff || (cfg_wr && reg_wdata[4])) ? 0 : cnt_ff + 1;
    end
  end
  // ****
  // Checks
  // ****
  chk_sync_phase: assert property (cfg_wr && reg_wdata[4] |-> ##2 blink_ff [*4])
    else $error("phase not primary after sync");
  chk_scan_restart: assert property (cfg_wr && reg_wdata[4] |-> ##[1:2] scan_digit_ff == 2'b00)
    else $error("scan not restarted by sync");
  chk_phase_read: assert property (cfg_rd |=> reg_rdata_ff[7] == $past(blink_ff))
    else $error("phase bit differs from blink pin");
  chk_cfg_zero: assert property (cfg_rd |=> reg_rdata_ff[6:4] == 3'b000 && !reg_rdata_ff[1])
    else $error("action bits read back set");
  chk_clear_digits: assert property (cfg_wr && reg_wdata[5] ##1 reg_rd && reg_addr[6:0] == 7'h20
    |=> reg_rdata_ff == 8'h00)
    else $error("digit not cleared");
  chk_font_msb: assert property (reg_rd && reg_addr[6:0] == 7'h05 |=> !reg_rdata_ff[7])
    else $error("font read with top bit set");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_ff))
    else $error("read data moved without read");
  chk_phase_len: assert property (cnt_ff <= SLOW_CYC + 2)
    else $error("blink phase stopped toggling");
endmodule // lmbf_checker

bind lmbf_core lmbf_checker #(.SLOW_CYC(SLOW_CYC)) u_chk (
  .clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_ff,
  .scan_digit_ff, .blink_ff);

// file: dv/lmbf_rom_model.sv
/* Stand-in for the external character ROM of lmbf_core.
   Answers combinationally; within one column every code gives its own pattern. */
`timescale 1ns/1ps
module lmbf_rom_model (
  // Lookup
  input wire [6:0] code,
  input wire [2:0] col,
  // Answer
  output wire [6:0] pattern
);
  // ****
  // Model
  // ****
  // Answers user codes too, so the core must choose RAM over this itself
  assign pattern = code ^ {col, 4'hA};
endmodule // lmbf_rom_model

// file: dv/test_lmbf_core.sv
/* Self-checking bench for lmbf_core with short blink counts.
   Assumes the bound checker and the ROM model answering at once. */
`timescale 1ns/1ps
module test_lmbf_core;
  localparam SLOW = 40;
  localparam FAST = 20;
  reg clk, rst, reg_wr, reg_rd, rd_q;
  reg [7:0] reg_addr, reg_wdata;
  reg [2:0] col_sel;
  wire [7:0] reg_rdata_ff;
  wire [6:0] rom_col, rom_code_ff, seg_ff;
  wire [1:0] scan_digit_ff;
  wire blink_ff, shutdown_n_ff;
  integer n_errors, n_tests, i, n, w, h;
  reg [15:0] exq[$];
  reg [15:0] e;
  reg [31:0] r;
  reg [6:0] ram0, last_custom_glyph;
  reg [6:0] d[0:2];
  reg [7:0] ca[0:2];
  reg [7:0] cb[0:2];

  lmbf_core #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) u_dut (.clk(clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .col_sel(col_sel), .rom_col(rom_col),
    .rom_code_ff(rom_code_ff), .scan_digit_ff(scan_digit_ff), .seg_ff(seg_ff),
    .blink_ff(blink_ff), .shutdown_n_ff(shutdown_n_ff));
  lmbf_rom_model u_rom (.code(rom_code_ff), .col(col_sel), .pattern(rom_col));

  // ****
  // Bench
  // ****
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task summarize;
    begin
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task cmp(input [7:0] got, input [7:0] exp, input [7:0] mask);
    begin
      n_tests = n_tests + 1;
      if ((got & mask) !== (exp & mask)) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One byte access per cycle; strobes stay up for back-to-back use
  task acc(input wr, input [7:0] a, input [7:0] dt);
    begin
      reg_wr = wr;
      reg_rd = !wr;
      reg_addr = a;
      reg_wdata = dt;
      @(negedge clk);
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp, input [7:0] mask);
    begin
      exq.push_back({mask, exp});
      acc(1'b0, a, 8'h00);
    end
  endtask
  task idle;
    begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      @(negedge clk);
    end
  endtask
  // Bounded wait for the alternate phase, counting cycles
  task wait_fall;
    begin
      w = 0;
      while (blink_ff !== 1'b0 && w < 200) begin
        @(negedge clk);
        w = w + 1;
      end
      if (w >= 200) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0t blink stuck", $time);
        summarize;
      end
    end
  endtask
  function [6:0] glyph(input [7:0] c);
    reg [6:0] g;
    begin
      if (c[6:0] == 7'h00)
        g = ram0;
      else if (c[6:0] == 7'h17)
        g = last_custom_glyph;
      else
        g = c[6:0] ^ {col_sel, 4'hA};
      glyph = c[7] ? ~g : g;
    end
  endfunction
  // Read data lands one edge after the strobe; match it against the oldest note
  always @(posedge clk) rd_q <= reg_rd;
  always @(negedge clk) begin
    if (rd_q === 1'b1) begin
      e = exq.pop_front();
      cmp(reg_rdata_ff, e[7:0], e[15:8]);
    end
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    col_sel = 3'h0;
    n_errors = 0;
    n_tests = 0;
    ca[0] = 8'h00; cb[0] = 8'h17;
    ca[1] = 8'h97; cb[1] = 8'h41;
    ca[2] = 8'h5A; cb[2] = 8'h80;
    r = $urandom(32'h3B50);
    repeat (3) @(negedge clk);
    rst = 1'b0;
    r = $urandom;
    col_sel = 3'(r % 5);
    rd(8'h04, 8'h00, 8'h7F);
    rd(8'h21, 8'h20, 8'hFF);
    // Wrap at the top, then reload and read back through the wrap
    for (i = 0; i < 3; i = i + 1) begin
      r = $urandom;
      d[i] = r[6:0];
    end
    acc(1'b1, 8'h05, 8'hF6);
    for (i = 0; i < 3; i = i + 1) acc(1'b1, 8'h05, {1'b0, d[i]});
    acc(1'b1, 8'h05, 8'hF6);
    for (i = 0; i < 3; i = i + 1) rd(8'h05, {1'b0, d[i]}, 8'hFF);
    acc(1'b1, 8'h05, 8'hFB);
    rd(8'h05, {1'b0, d[2]}, 8'hFF);
    // First and last user glyph columns
    r = $urandom;
    ram0 = r[6:0];
    last_custom_glyph = r[14:8];
    acc(1'b1, 8'h05, {5'b10000, col_sel});
    acc(1'b1, 8'h05, {1'b0, ram0});
    acc(1'b1, 8'h05, 8'hF3 + {5'b00000, col_sel});
    acc(1'b1, 8'h05, {1'b0, last_custom_glyph});
    acc(1'b1, 8'h04, 8'h21);
    rd(8'h20, 8'h00, 8'hFF);
    rd(8'h43, 8'h00, 8'hFF);
    acc(1'b1, 8'h04, 8'h3D);
    rd(8'h04, 8'h0D, 8'h7F);
    // Planes per phase, blink off then on, slow then fast
    for (i = 0; i < 3; i = i + 1) begin
      for (n = 0; n < 4; n = n + 1) begin
        acc(1'b1, 8'h20 + n[7:0], ca[i]);
        acc(1'b1, 8'h40 + n[7:0], cb[i]);
      end
      acc(1'b1, 8'h04, 8'h11);
      idle;
      wait_fall;
      repeat (8) @(negedge clk);
      cmp({1'b0, seg_ff}, {1'b0, glyph(ca[i])}, 8'hFF);
      acc(1'b1, 8'h04, (i == 2) ? 8'h1D : 8'h19);
      idle;
      h = (i == 2) ? FAST : SLOW;
      repeat (8) @(negedge clk);
      cmp({1'b0, seg_ff}, {1'b0, glyph(ca[i])}, 8'hFF);
      wait_fall;
      // Sync edge, h cycles of primary phase, one more for the pin register
      cmp({7'h00, w + 8 == h}, 8'h01, 8'hFF);
      repeat (8) @(negedge clk);
      cmp({1'b0, seg_ff}, {1'b0, glyph(cb[i])}, 8'hFF);
    end
    repeat (4) @(negedge clk);
    summarize;
  end
endmodule // test_lmbf_core
